// File: verilog/pmdi_pkg.sv
// ****************************************************************
// timing and layout constants of the page mode controller
// ****************************************************************
package pmdi_pkg;

  // ****************************************************************
  // address layout: ten row bits above ten column bits
  // ****************************************************************
  localparam int ADDR_W = 20;
  localparam int HALF_W = 10;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int ROW_LSB = 10;
  localparam int COL_LSB = 0;
  localparam int LANE_LO = 0;
  localparam int LANE_HI = 1;

  // ****************************************************************
  // times in their own units, as printed
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int TRAS_MIN_NS = 50;
  localparam int TRAS_MAX_NS = 10000;
  localparam int TRP_MIN_NS = 30;
  localparam int TCAS_MIN_NS = 8;
  localparam int TRAC_MAX_NS = 50;
  localparam int TCAC_MAX_NS = 13;
  localparam int TAA_MAX_NS = 25;
  localparam int REFRESH_PERIOD_US = 16000;
  localparam int REFRESH_ROWS = 1024;
  localparam int POWER_UP_US = 200;
  localparam int WAKE_CYCLES = 8;
  localparam int PAGE_MAX = 1024;

  // ****************************************************************
  // derived cycle counts: least times and the longest access delay round up, longest row and refresh times round down
  // ****************************************************************
  localparam int TRAS_CYC = (TRAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRP_CYC = (TRP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TCAS_CYC = (TCAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_MAX_NS = (TRAC_MAX_NS > TAA_MAX_NS) ?
    ((TRAC_MAX_NS > TCAC_MAX_NS) ? TRAC_MAX_NS : TCAC_MAX_NS) :
    ((TAA_MAX_NS > TCAC_MAX_NS) ? TAA_MAX_NS : TCAC_MAX_NS);
  localparam int ACC_CYC = (ACC_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAS_MAX_CYC = TRAS_MAX_NS / CLK_PERIOD_NS;
  localparam int REF_INT_CYC = (REFRESH_PERIOD_US * 1000 / REFRESH_ROWS) / CLK_PERIOD_NS;
  localparam int POWER_UP_CYC = (POWER_UP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_CYC = 4;
  localparam int READ_CAP_CYC = ACC_CYC + SYNC_CYC;
  localparam int RAS_GUARD_CYC = READ_CAP_CYC + 4;
  localparam int REF_LATE_CYC = REF_INT_CYC + RAS_MAX_CYC + 16;

  // ****************************************************************
  // controller states, one-hot
  // ****************************************************************
  typedef enum logic [8:0] {
    ST_WAKE = 9'h001,
    ST_IDLE = 9'h002,
    ST_ROW = 9'h004,
    ST_COL = 9'h008,
    ST_CAS = 9'h010,
    ST_PAGE = 9'h020,
    ST_PRE = 9'h040,
    ST_RCAS = 9'h080,
    ST_RRAS = 9'h100
  } pmdi_state_type;

endpackage : pmdi_pkg

// File: verilog/pmdi_pin_sync.sv
`timescale 1ns/100ps
// ****************************************************************
// three stage pin synchroniser with agreement filter
// ****************************************************************
module pmdi_pin_sync
  import pmdi_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] value_q
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] value_d;

  // per bit, a change counts once stages two and three agree
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++)
    begin : g_bit
      assign value_d[b] = (s2_q[b] == s3_q[b]) ? s3_q[b] : value_q[b];
    end
  endgenerate

  // first stage is only read by the second
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      value_q <= '0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      value_q <= value_d;
    end
  end

endmodule : pmdi_pin_sync

// File: verilog/pmdi_controller.sv
`timescale 1ns/100ps
module pmdi_controller
  import pmdi_pkg::*;
#(
  parameter int POWER_UP_COUNT = POWER_UP_CYC
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [1:0] req_byte_en,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready_q,
  output logic rsp_valid_q,
  output logic [DATA_W-1:0] rsp_rdata_q,
  output logic init_done_q,
  output logic row_strobe_n_q,
  output logic low_byte_col_strobe_n_q,
  output logic high_byte_col_strobe_n_q,
  output logic write_sel_n_q,
  output logic out_gate_n_q,
  output logic [HALF_W-1:0] mux_address_q,
  input wire logic [DATA_W-1:0] data_pins_in,
  output logic [DATA_W-1:0] data_pins_out_q,
  output logic [DATA_W-1:0] data_pins_oe_q
);

  // ****************************************************************
  // state and registers
  // ****************************************************************
  pmdi_state_type state_q, state_d;
  logic [11:0] timer_q, timer_d;
  logic [8:0] ras_cnt_q, ras_cnt_d;
  logic [3:0] pre_cnt_q;
  logic [10:0] page_cnt_q, page_cnt_d;
  logic [9:0] ref_gap_q, ref_gap_d;
  logic ref_pend_q, ref_pend_d;
  logic wake_need_q, wake_need_d;
  logic [3:0] wake_cnt_q, wake_cnt_d;
  logic op_pend_q, op_pend_d;
  logic op_we_q, op_we_d;
  logic [1:0] op_be_q, op_be_d;
  logic [ADDR_W-1:0] op_addr_q, op_addr_d;
  logic [DATA_W-1:0] op_wdata_q, op_wdata_d;
  logic [HALF_W-1:0] open_row_q, open_row_d;
  logic req_ready_d, rsp_valid_d, init_done_d;
  logic [DATA_W-1:0] rsp_rdata_d;
  logic row_strobe_n_d, low_n_d, high_n_d, write_sel_n_d, out_gate_n_d;
  logic [HALF_W-1:0] mux_address_d;
  logic [DATA_W-1:0] data_out_d, data_oe_d;
  logic [DATA_W-1:0] data_sync;

  // read data crosses in from the pins
  pmdi_pin_sync #(.WIDTH(DATA_W)) u_pmdi_pin_sync (
    .clock(clock),
    .rst(rst),
    .pin_in(data_pins_in),
    .value_q(data_sync)
  );

  // ****************************************************************
  // decode
  // ****************************************************************
  wire take = req_valid && req_ready_q;
  wire [HALF_W-1:0] req_row = req_addr[ROW_LSB +: HALF_W];
  wire [HALF_W-1:0] op_row = op_addr_q[ROW_LSB +: HALF_W];
  wire [HALF_W-1:0] op_col = op_addr_q[COL_LSB +: HALF_W];
  // one strobe mask per lane drives the enable of its eight pins
  wire [DATA_W-1:0] lane_mask = {{LANE_W{op_be_q[LANE_HI]}}, {LANE_W{op_be_q[LANE_LO]}}};
  wire page_room = (page_cnt_q < 11'(PAGE_MAX)) && (ras_cnt_q < 9'(RAS_MAX_CYC - RAS_GUARD_CYC));
  wire page_hit = (req_row == open_row_q) && page_room;
  wire tras_met = ras_cnt_q >= 9'(TRAS_CYC);
  wire trp_met = timer_q >= 12'(TRP_CYC);
  wire cas_done = timer_q >= (op_we_q ? 12'(TCAS_CYC) : 12'(READ_CAP_CYC));
  wire ref_due = ref_gap_q >= 10'(REF_INT_CYC);
  wire ref_late = ref_gap_q >= 10'(REF_LATE_CYC);
  wire last_wake = wake_cnt_q == 4'(WAKE_CYCLES - 1);
  wire busy_next = (state_d != ST_IDLE) && (state_d != ST_PAGE);

  // ****************************************************************
  // next state and pin values
  // ****************************************************************
  always_comb
  begin
    state_d = state_q;
    timer_d = (timer_q == 12'hFFF) ? timer_q : timer_q + 12'h001;
    ras_cnt_d = (ras_cnt_q == 9'h1FF) ? ras_cnt_q : ras_cnt_q + 9'h001;
    page_cnt_d = page_cnt_q;
    ref_gap_d = (ref_gap_q == 10'h3FF) ? ref_gap_q : ref_gap_q + 10'h001;
    // hardware sets, the refresh cycle clears; the clear wins in its own cycle by the guard below
    ref_pend_d = ref_pend_q;
    wake_need_d = wake_need_q;
    wake_cnt_d = wake_cnt_q;
    op_pend_d = op_pend_q;
    op_we_d = op_we_q;
    op_be_d = op_be_q;
    op_addr_d = op_addr_q;
    op_wdata_d = op_wdata_q;
    open_row_d = open_row_q;
    rsp_valid_d = 1'b0;
    rsp_rdata_d = rsp_rdata_q;
    init_done_d = init_done_q;
    row_strobe_n_d = row_strobe_n_q;
    low_n_d = low_byte_col_strobe_n_q;
    high_n_d = high_byte_col_strobe_n_q;
    write_sel_n_d = write_sel_n_q;
    out_gate_n_d = out_gate_n_q;
    mux_address_d = mux_address_q;
    data_out_d = data_pins_out_q;
    data_oe_d = data_pins_oe_q;
    unique case (state_q)
      ST_WAKE:
      begin
        // row strobe stays high while the supply settles
        if (timer_q >= 12'(POWER_UP_COUNT))
        begin
          state_d = ST_RCAS;
        end
      end
      ST_IDLE:
      begin
        if (wake_need_q || ref_pend_q)
        begin
          state_d = ST_RCAS;
        end
        else if (take)
        begin
          op_we_d = req_write;
          op_be_d = req_byte_en;
          op_addr_d = req_addr;
          op_wdata_d = req_wdata;
          mux_address_d = req_row; // row half first
          state_d = ST_ROW;
        end
      end
      ST_ROW:
      begin
        // row strobe falls on a stable row half; this also refreshes it
        row_strobe_n_d = 1'b0;
        ras_cnt_d = '0;
        page_cnt_d = '0;
        open_row_d = op_row;
        state_d = ST_COL;
      end
      ST_COL:
      begin
        // column half and early write data ahead of the strobes
        mux_address_d = op_col;
        write_sel_n_d = !op_we_q;
        data_out_d = op_wdata_q;
        data_oe_d = op_we_q ? lane_mask : '0; // undriven lane stays tristate
        timer_d = '0;
        state_d = ST_CAS;
      end
      ST_CAS:
      begin
        // per lane strobes; gate only for reads
        low_n_d = !op_be_q[LANE_LO];
        high_n_d = !op_be_q[LANE_HI];
        out_gate_n_d = op_we_q;
        if (cas_done)
        begin
          // read sampled after longest access delay plus sync
          if (!op_we_q)
          begin
            rsp_valid_d = 1'b1;
            rsp_rdata_d = data_sync & lane_mask;
          end
          low_n_d = 1'b1;
          high_n_d = 1'b1;
          out_gate_n_d = 1'b1;
          write_sel_n_d = 1'b1;
          data_oe_d = '0;
          page_cnt_d = page_cnt_q + 11'h001;
          state_d = ST_PAGE;
        end
      end
      ST_PAGE:
      begin
        // row stays open for further columns
        if (take)
        begin
          op_we_d = req_write;
          op_be_d = req_byte_en;
          op_addr_d = req_addr;
          op_wdata_d = req_wdata;
          op_pend_d = !page_hit;
          state_d = page_hit ? ST_COL : ST_PAGE;
        end
        // close only after least active time; a parked miss must close too
        if (tras_met && ((take && !page_hit) || (!take && (ref_pend_q || op_pend_q || !page_room))))
        begin
          row_strobe_n_d = 1'b1;
          timer_d = '0;
          state_d = ST_PRE;
        end
      end
      ST_PRE:
      begin
        // precharge before any new row strobe fall
        if (trp_met)
        begin
          if (wake_need_q || ref_pend_q)
          begin
            state_d = ST_RCAS;
          end
          else if (op_pend_q)
          begin
            mux_address_d = op_row;
            op_pend_d = 1'b0;
            state_d = ST_ROW;
          end
          else
          begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_RCAS:
      begin
        // column strobes low first, no data driven
        low_n_d = 1'b0;
        high_n_d = 1'b0;
        data_oe_d = '0;
        state_d = ST_RRAS;
      end
      ST_RRAS:
      begin
        // counter refresh: row strobe falls with strobes low
        row_strobe_n_d = 1'b0;
        if (!row_strobe_n_q && tras_met)
        begin
          row_strobe_n_d = 1'b1;
          low_n_d = 1'b1;
          high_n_d = 1'b1;
          timer_d = '0;
          ref_gap_d = '0;
          ref_pend_d = 1'b0;
          if (wake_need_q)
          begin
            wake_cnt_d = wake_cnt_q + 4'h1;
            wake_need_d = !last_wake;
            init_done_d = init_done_q || last_wake;
          end
          state_d = ST_PRE;
        end
        else if (row_strobe_n_q)
        begin
          ras_cnt_d = '0;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
    // late recovery set last so it wins; refresh request set last but skipped in the cycle that clears it
    if (ref_due && !(state_q == ST_RRAS && state_d == ST_PRE))
    begin
      ref_pend_d = 1'b1;
    end
    if (ref_late && init_done_q)
    begin
      wake_need_d = 1'b1;
      wake_cnt_d = '0;
    end
    req_ready_d = init_done_d && !busy_next && !ref_pend_d && !wake_need_d && !op_pend_d;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q <= ST_WAKE;
      timer_q <= '0;
      ras_cnt_q <= '0;
      page_cnt_q <= '0;
      ref_gap_q <= '0;
      ref_pend_q <= 1'b0;
      wake_need_q <= 1'b1;
      wake_cnt_q <= '0;
      op_pend_q <= 1'b0;
      op_we_q <= 1'b0;
      op_be_q <= '0;
      op_addr_q <= '0;
      op_wdata_q <= '0;
      open_row_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      timer_q <= timer_d;
      ras_cnt_q <= ras_cnt_d;
      page_cnt_q <= page_cnt_d;
      ref_gap_q <= ref_gap_d;
      ref_pend_q <= ref_pend_d;
      wake_need_q <= wake_need_d;
      wake_cnt_q <= wake_cnt_d;
      op_pend_q <= op_pend_d;
      op_we_q <= op_we_d;
      op_be_q <= op_be_d;
      op_addr_q <= op_addr_d;
      op_wdata_q <= op_wdata_d;
      open_row_q <= open_row_d;
    end
  end

  // pins idle in standby: strobes high, bus undriven
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      req_ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= '0;
      init_done_q <= 1'b0;
      row_strobe_n_q <= 1'b1;
      low_byte_col_strobe_n_q <= 1'b1;
      high_byte_col_strobe_n_q <= 1'b1;
      write_sel_n_q <= 1'b1;
      out_gate_n_q <= 1'b1;
      mux_address_q <= '0;
      data_pins_out_q <= '0;
      data_pins_oe_q <= '0;
    end
    else
    begin
      req_ready_q <= req_ready_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_rdata_q <= rsp_rdata_d;
      init_done_q <= init_done_d;
      row_strobe_n_q <= row_strobe_n_d;
      low_byte_col_strobe_n_q <= low_n_d;
      high_byte_col_strobe_n_q <= high_n_d;
      write_sel_n_q <= write_sel_n_d;
      out_gate_n_q <= out_gate_n_d;
      mux_address_q <= mux_address_d;
      data_pins_out_q <= data_out_d;
      data_pins_oe_q <= data_oe_d;
    end
  end

  // high time of row strobe, for the precharge check
  always_ff @(posedge clock)
  begin
    if (rst)
      pre_cnt_q <= '0;
    else if (!row_strobe_n_q)
      pre_cnt_q <= '0;
    else if (pre_cnt_q != 4'hF)
      pre_cnt_q <= pre_cnt_q + 4'h1;
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  wire any_cas_n = low_byte_col_strobe_n_q && high_byte_col_strobe_n_q;

  AST_ROW_STABLE: assert property (@(posedge clock) disable iff (rst)
    $fell(row_strobe_n_q) |-> $stable(mux_address_q))
    else $error("row half changed as row strobe fell");
  AST_CAS_IN_ROW: assert property (@(posedge clock) disable iff (rst)
    ($fell(any_cas_n) && state_q == ST_CAS) |-> !row_strobe_n_q)
    else $error("column strobe fell outside open row");
  AST_TRAS: assert property (@(posedge clock) disable iff (rst)
    $rose(row_strobe_n_q) |-> $past(ras_cnt_q) >= 9'(TRAS_CYC))
    else $error("row strobe released before least active time");
  AST_TRP: assert property (@(posedge clock) disable iff (rst)
    $fell(row_strobe_n_q) |-> $past(pre_cnt_q) >= 4'(TRP_CYC))
    else $error("row strobe fell before precharge elapsed");
  AST_WDATA_EARLY: assert property (@(posedge clock) disable iff (rst)
    ($fell(any_cas_n) && !write_sel_n_q) |-> $past(data_pins_oe_q) != '0)
    else $error("write data not driven before strobe fell");
  AST_LANE_DRIVE: assert property (@(posedge clock) disable iff (rst)
    (data_pins_oe_q != '0) |-> (data_pins_oe_q == lane_mask && op_we_q))
    else $error("undriven lane was driven");
  AST_READ_RSP: assert property (@(posedge clock) disable iff (rst)
    ($fell(any_cas_n) && write_sel_n_q && !out_gate_n_q) |-> ##(READ_CAP_CYC) rsp_valid_q)
    else $error("read answer not at access plus sync time");
  AST_REF_RATE: assert property (@(posedge clock) disable iff (rst)
    init_done_q |-> ref_gap_q <= 10'(REF_LATE_CYC))
    else $error("refresh interval overrun");
  AST_COUNTER_REF_ORDER: assert property (@(posedge clock) disable iff (rst)
    ($fell(row_strobe_n_q) && state_q == ST_RRAS) |-> !$past(any_cas_n) && data_pins_oe_q == '0)
    else $error("counter refresh without strobe low first");
  AST_POWER_UP: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_WAKE) |-> row_strobe_n_q && !req_ready_q)
    else $error("row strobe moved during power-up wait");

  COV_READ: cover property (@(posedge clock) disable iff (rst) rsp_valid_q);
  COV_WRITE: cover property (@(posedge clock) disable iff (rst) $fell(any_cas_n) && !write_sel_n_q);
  COV_PAGE_HIT: cover property (@(posedge clock) disable iff (rst) state_q == ST_PAGE && take && page_hit);
  COV_REFRESH: cover property (@(posedge clock) disable iff (rst) state_q == ST_RRAS && init_done_q);

endmodule : pmdi_controller

// File: testbench/pmdi_dram_model.sv
`timescale 1ns/100ps
// ****************************************
// behavioural page mode memory at the far side
// ****************************************
module pmdi_dram_model
  import pmdi_pkg::*;
(
  input wire logic ras_n,
  input wire logic low_strobe_n,
  input wire logic high_strobe_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [HALF_W-1:0] addr,
  input wire logic [DATA_W-1:0] bus,
  input wire logic [DATA_W-1:0] host_oe,
  output logic [DATA_W-1:0] dq_out,
  output logic [DATA_W-1:0] dq_oe,
  output int ref_count,
  output int row_opens,
  output int viol_count
);
  logic [DATA_W-1:0] mem [int];
  logic [HALF_W-1:0] row = '0;
  logic rd_ok = 1'b0;
  realtime t_fall = -1.0e6;
  realtime t_rise = -1.0e6;
  realtime d;
  int key;
  // combined column strobe and its lane map
  wire cas_n = low_strobe_n & high_strobe_n;
  wire [DATA_W-1:0] lanes = {{LANE_W{!high_strobe_n}}, {LANE_W{!low_strobe_n}}};

  // counters start clear; pins start undriven
  initial
  begin
    ref_count = 0;
    row_opens = 0;
    viol_count = 0;
    dq_out = '0;
  end

  // row strobe fall: refresh by counter or row capture
  always @(negedge ras_n)
  begin
    if ($realtime - t_rise < TRP_MIN_NS) viol_count++;
    t_fall = $realtime;
    if (!cas_n) ref_count++;
    else row = addr;
    if (cas_n) row_opens++;
  end

  // row strobe rise: the row must have stayed open long enough
  always @(posedge ras_n)
  begin
    if ($realtime - t_fall < TRAS_MIN_NS) viol_count++;
    t_rise = $realtime;
  end

  // column fall with row open: early write, or read once all delays are met
  always @(negedge cas_n)
  begin
    key = {row, addr};
    if (!ras_n && !we_n)
    begin
      if ((host_oe & lanes) !== lanes || (host_oe & ~lanes) !== '0) viol_count++;
      mem[key] = ((mem.exists(key) ? mem[key] : '0) & ~lanes) | (bus & lanes);
    end
    if (!ras_n && we_n)
    begin
      dq_out = mem.exists(key) ? mem[key] : '0;
      d = t_fall + TRAC_MAX_NS - $realtime;
      if (d < TAA_MAX_NS) d = TAA_MAX_NS;
      fork
        #(d) rd_ok = !cas_n;
      join_none
    end
  end

  // drive ends with the last column strobe rise
  always @(posedge cas_n) rd_ok = 1'b0;
  // lanes drive only in a read; a refresh by counter never sets rd_ok
  assign dq_oe = (rd_ok && we_n && !oe_n) ? lanes : '0;
  // both sides driving one pin at once is a fault
  always @(dq_oe, host_oe) if (|(dq_oe & host_oe)) viol_count++;
endmodule : pmdi_dram_model

// File: testbench/page_mode_dram_interface_tb.sv
`timescale 1ns/100ps
// ****************************************
// controller against the memory model
// ****************************************
module page_mode_dram_interface_tb
  import pmdi_pkg::*;
;
  localparam int PU = 20;
  localparam logic [ADDR_W-1:0] A = {10'h155, 10'h2AA};
  localparam logic [ADDR_W-1:0] B = {10'h155, 10'h0F0};
  localparam logic [ADDR_W-1:0] C = {10'h2AA, 10'h155};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [1:0] req_byte_en = 2'h0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic req_ready_q, rsp_valid_q, init_done_q, row_strobe_n_q, low_byte_col_strobe_n_q;
  logic high_byte_col_strobe_n_q, write_sel_n_q, out_gate_n_q;
  logic [HALF_W-1:0] mux_address_q;
  logic [DATA_W-1:0] rsp_rdata_q, data_pins_out_q, data_pins_oe_q, dq_out, dq_oe, rd;
  logic [DATA_W-1:0] float_q = 16'h5A5A;
  int ref_count, row_opens, viol_count, c1, r1;
  int failures = 0;
  int n_checks = 0;
  // undriven pins show a pattern that flips every cycle, not a kept value
  wire [DATA_W-1:0] bus = (data_pins_oe_q & data_pins_out_q) | (~data_pins_oe_q & dq_oe & dq_out)
    | (~data_pins_oe_q & ~dq_oe & float_q);

  always #25 clock = ~clock;
  always @(posedge clock) float_q <= ~float_q;

  pmdi_controller #(.POWER_UP_COUNT(PU)) u_pmdi_controller (.clock(clock), .rst(rst), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_byte_en(req_byte_en), .req_wdata(req_wdata),
    .req_ready_q(req_ready_q), .rsp_valid_q(rsp_valid_q), .rsp_rdata_q(rsp_rdata_q), .init_done_q(init_done_q),
    .row_strobe_n_q(row_strobe_n_q), .low_byte_col_strobe_n_q(low_byte_col_strobe_n_q),
    .high_byte_col_strobe_n_q(high_byte_col_strobe_n_q), .write_sel_n_q(write_sel_n_q),
    .out_gate_n_q(out_gate_n_q), .mux_address_q(mux_address_q), .data_pins_in(bus),
    .data_pins_out_q(data_pins_out_q), .data_pins_oe_q(data_pins_oe_q));
  pmdi_dram_model u_pmdi_dram_model (.ras_n(row_strobe_n_q), .low_strobe_n(low_byte_col_strobe_n_q),
    .high_strobe_n(high_byte_col_strobe_n_q), .we_n(write_sel_n_q), .oe_n(out_gate_n_q), .addr(mux_address_q),
    .bus(bus), .host_oe(data_pins_oe_q), .dq_out(dq_out), .dq_oe(dq_oe), .ref_count(ref_count),
    .row_opens(row_opens), .viol_count(viol_count));

  task conclude;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one request held until taken; reads wait for the answer pulse
  task access(input logic wr, input logic [ADDR_W-1:0] a, input logic [1:0] be, input logic [DATA_W-1:0] wd,
    output logic [DATA_W-1:0] q);
    int i;
    i = 0;
    q = '0;
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_byte_en <= be;
    req_wdata <= wd;
    do begin @(posedge clock); i++; end while (req_ready_q !== 1'b1 && i < 2000);
    req_valid <= 1'b0;
    if (i >= 2000) begin chk("ready_wait", 1, 0); conclude(); end
    i = 0;
    if (!wr) do begin @(posedge clock); i++; end while (rsp_valid_q !== 1'b1 && i < 100);
    if (i >= 100) begin chk("answer_wait", 1, 0); conclude(); end
    q = rsp_rdata_q;
  endtask : access

  // reset, power-up hold, wake refreshes
  task t_wake;
    int i, lows;
    lows = 0;
    for (i = 0; i < 20 + PU; i++)
    begin
      @(posedge clock);
      if (i == 19) rst <= 1'b0;
      if (i > 0 && row_strobe_n_q !== 1'b1) lows++;
    end
    chk("row_strobe_held_high", 0, lows);
    i = 0;
    while (init_done_q !== 1'b1 && i < 500) begin @(posedge clock); i++; end
    chk("init_done", 1, init_done_q);
    if (i >= 500) conclude();
    chk("wake_refreshes", WAKE_CYCLES, ref_count);
    chk("no_access_before_init", 0, row_opens);
    $display("t_wake done");
  endtask : t_wake

  task t_word;
    access(1'b1, A, 2'b11, 16'hA5C3, rd);
    access(1'b0, A, 2'b11, '0, rd);
    chk("word_read", 16'hA5C3, rd);
    $display("t_word done");
  endtask : t_word

  // byte writes keep the other lane; byte reads return only their lane
  task t_bytes;
    access(1'b1, B, 2'b11, 16'h1234, rd);
    access(1'b1, B, 2'b01, 16'hFF77, rd);
    access(1'b1, B, 2'b10, 16'h88FF, rd);
    access(1'b0, B, 2'b11, '0, rd);
    chk("byte_writes", 16'h8877, rd);
    access(1'b0, B, 2'b01, '0, rd);
    chk("low_byte_read", 16'h0077, rd);
    access(1'b0, B, 2'b10, '0, rd);
    chk("high_byte_read", 16'h8800, rd);
    chk("pin_faults", 0, viol_count);
    $display("t_bytes done");
  endtask : t_bytes

  // same row stays open; a new row opens exactly once
  task t_page;
    access(1'b1, C, 2'b11, 16'h5AF0, rd);
    access(1'b0, A, 2'b11, '0, rd);
    r1 = row_opens;
    c1 = ref_count;
    access(1'b0, B, 2'b11, '0, rd);
    chk("page_read", 16'h8877, rd);
    chk("page_row_reuse", ref_count - c1, row_opens - r1);
    r1 = row_opens;
    access(1'b0, C, 2'b11, '0, rd);
    chk("other_row_read", 16'h5AF0, rd);
    chk("row_switch", 1, row_opens - r1);
    $display("t_page done");
  endtask : t_page

  // idle long enough for two refresh intervals
  task t_refresh;
    c1 = ref_count;
    repeat (2 * REF_INT_CYC + 40) @(posedge clock);
    chk("refresh_rate", 1, {31'h0, ref_count - c1 >= 2});
    chk("timing_faults", 0, viol_count);
    $display("t_refresh done");
  endtask : t_refresh

  initial
  begin
    t_wake();
    t_word();
    t_bytes();
    t_page();
    t_refresh();
    conclude();
  end
endmodule : page_mode_dram_interface_tb
